// [common/ifsc_pkg.sv]
// Package for the internal flash and SRAM controller: memory map, sizes, timing.
// Assumes one system clock and a synchronous active-high reset.
package ifsc_pkg;
  // ---------------------------------------------------------------
  // Memory map and sizes
  // ---------------------------------------------------------------
  localparam logic [31:0] IFSC_SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] IFSC_ALIAS_BASE = 32'h2200_0000;
  localparam int IFSC_SRAM_BYTES = 65536;
  localparam int IFSC_SRAM_AW = 14;
  localparam int IFSC_FLASH_BYTES = 262144;
  localparam int IFSC_FLASH_AW = 16;
  localparam int IFSC_UNIT_WORDS = 256;
  localparam int IFSC_UNIT_AW = 8;
  localparam int IFSC_REGIONS = 128;
  localparam int IFSC_REGION_SHIFT = 9;
  localparam int IFSC_ALIAS_BYTE_SHIFT = 5;
  localparam int IFSC_ALIAS_BIT_SHIFT = 2;
  localparam logic [31:0] IFSC_WORD_ONES = 32'hffff_ffff;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int IFSC_MAX_MHZ = 50;
  localparam logic [7:0] IFSC_USEC_RESET = 8'(IFSC_MAX_MHZ - 1);
  localparam logic [15:0] IFSC_PROG_US = 16'h0014;
  localparam logic [15:0] IFSC_ERASE_US = 16'h0010;
  // ---------------------------------------------------------------
  // Operation states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IFSC_IDLE = 2'b00,
    IFSC_PROG = 2'b01,
    IFSC_ERASE = 2'b10
  } ifsc_state_e;
endpackage : ifsc_pkg

// [rtl/ifsc_usec_timer.sv]
// Microsecond timer: counts a number of microseconds from a cycles-per-us reload.
// Assumes start only while idle; reload value is cycles per us minus one.
`timescale 1ns/10ps
`default_nettype none
module ifsc_usec_timer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] num_us,
  input wire logic [7:0] reload,
  output logic done
);
  import ifsc_pkg::*;
  logic [7:0] tick_cnt;
  logic [15:0] us_left;
  logic running;
  // ---------------------------------------------------------------
  // Prescaler and microsecond count
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt <= 8'h00;
      us_left <= 16'h0000;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        tick_cnt <= reload;
        us_left <= num_us;
        running <= 1'b1;
      end else if (running) begin
        if (tick_cnt == 8'h00) begin
          tick_cnt <= reload;
          if (us_left <= 16'h0001) begin
            running <= 1'b0;
            done <= 1'b1;
          end else begin
            us_left <= us_left - 16'h0001;
          end
        end else begin
          tick_cnt <= tick_cnt - 8'h01;
        end
      end
    end
  end
endmodule : ifsc_usec_timer
`default_nettype wire

// [rtl/ifsc_ctrl.sv]
// Internal flash and SRAM controller: SRAM with bit alias, flash with timed ops.
// Assumes single-cycle requests from a synchronous bus; memories are modelled arrays.
//
// Overview of operation
// - 64 KB SRAM and 256 KB flash.
// - SRAM decoded from base 0x2000_0000.
// - Alias = base + offset*32 + bit*4.
// - Alias access touches one bit, atomically.
// - Flash erases in independent 1 KB units.
// - Erase leaves every unit bit at one.
// - Program one word, only clearing bits.
// - Two units form one protection region.
// - Read-only regions refuse program and erase.
// - Execute-only regions serve fetches only.
// - Op timing from cycles-per-microsecond count.
// - Reset count suits highest clock rate.
// - Blocked data read gives bus fault.
// - Protected program/erase raises access event when idle.
// - Finished program/erase raises completion event.
`timescale 1ns/10ps
`default_nettype none
module ifsc_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic rd_fetch,
  input wire logic wr_req,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  output logic rd_valid,
  output logic bus_fault,
  input wire logic prog_req,
  input wire logic erase_req,
  input wire logic [ifsc_pkg::IFSC_FLASH_AW-1:0] flash_word,
  input wire logic [31:0] prog_data,
  input wire logic usec_wr,
  input wire logic [7:0] usec_wdata,
  input wire logic [ifsc_pkg::IFSC_REGIONS-1:0] perm_wr_clear,
  input wire logic perm_sel_read,
  output logic [7:0] microsecond_reload_count,
  output logic [ifsc_pkg::IFSC_REGIONS-1:0] block_program_permit,
  output logic [ifsc_pkg::IFSC_REGIONS-1:0] block_read_permit,
  output logic busy,
  output logic op_done,
  output logic access_event
);
  import ifsc_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] sram_mem [IFSC_SRAM_BYTES/4];
  logic [31:0] flash_mem [IFSC_FLASH_BYTES/4];
  ifsc_state_e state;
  logic [IFSC_FLASH_AW-1:0] op_word;
  logic [31:0] op_data;
  logic [IFSC_FLASH_AW-IFSC_UNIT_AW-1:0] op_unit;
  logic timer_start;
  logic timer_done;
  logic [15:0] timer_us;

  function automatic logic [6:0] region_of(input logic [IFSC_FLASH_AW-1:0] w);
    region_of = w[IFSC_FLASH_AW-1:IFSC_REGION_SHIFT];
  endfunction : region_of

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic is_sram;
  logic is_alias;
  logic is_flash;
  logic [IFSC_SRAM_AW-1:0] sram_word;
  logic [4:0] alias_bit;
  logic [IFSC_FLASH_AW-1:0] rd_flash_word;
  logic [15:0] sram_byte;
  always_comb begin
    is_sram = addr[31:16] == IFSC_SRAM_BASE[31:16];
    // The alias window spans 2 MB so that every byte of the 64 KB has its bits
    is_alias = addr[31:21] == IFSC_ALIAS_BASE[31:21];
    is_flash = addr[31:18] == 14'h0000;
    // Byte offset = (addr - base) / 32; bit = (addr / 4) mod 8
    sram_byte = addr[IFSC_ALIAS_BYTE_SHIFT+15:IFSC_ALIAS_BYTE_SHIFT];
    if (is_alias) begin
      sram_word = sram_byte[15:2];
      alias_bit = {sram_byte[1:0], addr[IFSC_ALIAS_BIT_SHIFT+2:IFSC_ALIAS_BIT_SHIFT]};
    end else begin
      sram_word = addr[IFSC_SRAM_AW+1:2];
      alias_bit = 5'h00;
    end
    rd_flash_word = addr[IFSC_FLASH_AW+1:2];
  end

  // ---------------------------------------------------------------
  // Bus reads and SRAM writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
      rd_valid <= 1'b0;
      bus_fault <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      bus_fault <= 1'b0;
      if (rd_req) begin
        if (is_alias) begin
          rdata <= {31'h0000_0000, sram_mem[sram_word][alias_bit]};
          rd_valid <= 1'b1;
        end else if (is_sram) begin
          rdata <= sram_mem[sram_word];
          rd_valid <= 1'b1;
        end else if (is_flash) begin
          if (rd_fetch || block_read_permit[region_of(rd_flash_word)]) begin
            rdata <= flash_mem[rd_flash_word];
            rd_valid <= 1'b1;
          end else begin
            rdata <= 32'h0000_0000;
            bus_fault <= 1'b1;
          end
        end else begin
          rdata <= 32'h0000_0000;
          bus_fault <= 1'b1;
        end
      end
    end
  end

  // Single-cycle update keeps the alias write atomic to other requesters
  always_ff @(posedge clk_sys) begin
    if (wr_req && !rd_req) begin
      if (is_alias) begin
        sram_mem[sram_word][alias_bit] <= wdata[0];
      end else if (is_sram) begin
        sram_mem[sram_word] <= wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timing and protection registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      microsecond_reload_count <= IFSC_USEC_RESET;
    end else if (usec_wr) begin
      microsecond_reload_count <= usec_wdata;
    end
  end

  // Permits only ever clear until reset; they never grant more access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      block_program_permit <= '1;
      block_read_permit <= '1;
    end else if (perm_sel_read) begin
      block_read_permit <= block_read_permit & ~perm_wr_clear;
    end else begin
      block_program_permit <= block_program_permit & ~perm_wr_clear;
    end
  end

  // ---------------------------------------------------------------
  // Program and erase sequencer
  // ---------------------------------------------------------------
  logic mod_req;
  logic permitted;
  always_comb begin
    mod_req = prog_req || erase_req;
    permitted = block_program_permit[region_of(flash_word)];
    timer_start = (state == IFSC_IDLE) && mod_req && permitted;
    timer_us = prog_req ? IFSC_PROG_US : IFSC_ERASE_US;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= IFSC_IDLE;
      op_word <= '0;
      op_data <= 32'h0000_0000;
      busy <= 1'b0;
      op_done <= 1'b0;
      access_event <= 1'b0;
    end else begin
      op_done <= 1'b0;
      access_event <= 1'b0;
      case (state)
        IFSC_IDLE: begin
          if (mod_req && !permitted) begin
            access_event <= 1'b1;
          end else if (timer_start) begin
            state <= prog_req ? IFSC_PROG : IFSC_ERASE;
            op_word <= flash_word;
            op_data <= prog_data;
            busy <= 1'b1;
          end
        end
        IFSC_PROG, IFSC_ERASE: begin
          // Requests arriving here are dropped, not queued
          if (timer_done) begin
            state <= IFSC_IDLE;
            busy <= 1'b0;
            op_done <= 1'b1;
          end
        end
        default: begin
          state <= IFSC_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  assign op_unit = op_word[IFSC_FLASH_AW-1:IFSC_UNIT_AW];

  // Array update at op end; one process owns the array, erase is applied in one step
  always_ff @(posedge clk_sys) begin
    if (timer_done && state == IFSC_PROG) begin
      flash_mem[op_word] <= flash_mem[op_word] & op_data;
    end else if (timer_done && state == IFSC_ERASE) begin
      for (int i = 0; i < IFSC_UNIT_WORDS; i++) begin
        flash_mem[{op_unit, IFSC_UNIT_AW'(i)}] <= IFSC_WORD_ONES;
      end
    end
  end

  ifsc_usec_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(timer_start),
    .num_us(timer_us),
    .reload(microsecond_reload_count),
    .done(timer_done)
  );
endmodule : ifsc_ctrl
`default_nettype wire

// [verif/ifsc_ctrl_assertions.sv]
// Port checker for the flash and SRAM controller.
// Assumes the reload count stays put while an operation runs.
`timescale 1ns/10ps
`default_nettype none
module ifsc_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic rd_fetch,
  input wire logic [31:0] addr,
  input wire logic rd_valid,
  input wire logic bus_fault,
  input wire logic prog_req,
  input wire logic erase_req,
  input wire logic [ifsc_pkg::IFSC_FLASH_AW-1:0] flash_word,
  input wire logic [7:0] microsecond_reload_count,
  input wire logic [ifsc_pkg::IFSC_REGIONS-1:0] block_program_permit,
  input wire logic [ifsc_pkg::IFSC_REGIONS-1:0] block_read_permit,
  input wire logic busy,
  input wire logic op_done,
  input wire logic access_event
);
  import ifsc_pkg::*;
  wire logic mod_req = !busy && (prog_req || erase_req);
  wire logic flash_rd = rd_req && addr < 32'h0004_0000;
  logic [15:0] busy_cnt;
  // Counts sampled busy cycles, too long a span for a repetition
  always_ff @(posedge clk_sys) begin
    if (rst || !busy) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_reset_vals;
    $past(rst) |-> microsecond_reload_count == 8'h31 && &block_read_permit;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_rd_answer;
    rd_req |=> rd_valid != bus_fault;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered once");
  property p_fetch_ok;
    flash_rd && rd_fetch |=> rd_valid;
  endproperty
  a_fetch_ok: assert property (p_fetch_ok) else $error("fetch refused");
  property p_prot_read;
    flash_rd && !rd_fetch && !block_read_permit[addr[17:11]] |=> bus_fault;
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protected read served");
  property p_prot_mod;
    mod_req && !block_program_permit[flash_word[15:9]] |=> access_event && !busy;
  endproperty
  a_prot_mod: assert property (p_prot_mod) else $error("protected modify taken");
  property p_busy_start;
    mod_req && block_program_permit[flash_word[15:9]] |=> busy && !access_event;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");
  property p_done_end;
    op_done |-> !busy && $past(busy);
  endproperty
  a_done_end: assert property (p_done_end) else $error("done without busy end");
  property p_op_time;
    op_done |-> int'(busy_cnt) == (int'(microsecond_reload_count) + 1) * int'(IFSC_PROG_US) + 1
      || int'(busy_cnt) == (int'(microsecond_reload_count) + 1) * int'(IFSC_ERASE_US) + 1;
  endproperty
  a_op_time: assert property (p_op_time) else $error("operation overran");
endmodule : ifsc_ctrl_assertions
bind ifsc_ctrl ifsc_ctrl_assertions u_chk (.clk_sys, .rst, .rd_req, .rd_fetch, .addr, .rd_valid,
  .bus_fault, .prog_req, .erase_req, .flash_word, .microsecond_reload_count,
  .block_program_permit, .block_read_permit, .busy, .op_done, .access_event);
`default_nettype wire

// [verif/ifsc_host_model.sv]
// Host model: loads the cycles-per-microsecond count once after reset.
// Assumes one bench cycle stands for one microsecond.
`timescale 1ns/10ps
`default_nettype none
module ifsc_host_model #(
  parameter logic [7:0] MHZ_M1 = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic usec_wr,
  output logic [7:0] usec_wdata
);
  logic sent;
  // ---------------------------------------------------------------
  // Reload once after reset
  // ---------------------------------------------------------------
  // Short count keeps timed operations brief in simulation
  assign usec_wdata = MHZ_M1;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      usec_wr <= 1'b0;
      sent <= 1'b0;
    end else begin
      usec_wr <= !sent;
      sent <= 1'b1;
    end
  end
endmodule : ifsc_host_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the flash and SRAM controller.
// Assumes the host model lowers the reload count right after reset.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ifsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rd_req = 1'b0, rd_fetch = 1'b0, wr_req = 1'b0, prog_req = 1'b0, erase_req = 1'b0;
  logic perm_sel_read = 1'b0;
  logic [31:0] addr = '0, wdata = '0, prog_data = '0, rdata, d1, d2;
  logic [15:0] flash_word = '0;
  logic [IFSC_REGIONS-1:0] perm_wr_clear = '0, ppermit, rpermit;
  logic [7:0] usec_wdata, ucount;
  logic usec_wr, rd_valid, bus_fault, busy, op_done, access_event;
  logic [32:0] exp_q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 65075;
  // Reload of zero makes one cycle stand for one microsecond
  localparam logic [7:0] RELOAD = 8'h00;
  localparam int PROG_N = (int'(RELOAD) + 1) * int'(IFSC_PROG_US) + 2;
  localparam int ERASE_N = (int'(RELOAD) + 1) * int'(IFSC_ERASE_US) + 2;
  always #4 clk_sys = ~clk_sys;
  ifsc_host_model #(.MHZ_M1(RELOAD)) host (.clk_sys, .rst, .usec_wr, .usec_wdata);
  ifsc_ctrl DUT (.clk_sys, .rst, .rd_req, .rd_fetch, .wr_req, .addr, .wdata, .rdata, .rd_valid,
    .bus_fault, .prog_req, .erase_req, .flash_word, .prog_data, .usec_wr, .usec_wdata,
    .perm_wr_clear, .perm_sel_read, .microsecond_reload_count(ucount),
    .block_program_permit(ppermit), .block_read_permit(rpermit), .busy, .op_done, .access_event);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, input logic f, input logic [32:0] e);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_fetch <= f;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    rd_req <= 1'b0;
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_req <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_req <= 1'b0;
  endtask : wr
  task automatic op(input logic p, input logic [15:0] w, input logic [31:0] d);
    @(posedge clk_sys);
    prog_req <= p;
    erase_req <= !p;
    flash_word <= w;
    prog_data <= d;
    @(posedge clk_sys);
    prog_req <= 1'b0;
    erase_req <= 1'b0;
  endtask : op
  // Counts falling edges until the end event; the count pins down the op time
  task automatic wait_end(input logic ev, input int cyc);
    int n = 0;
    while (n < 500 && !(op_done || access_event)) begin
      @(negedge clk_sys);
      n++;
    end
    chk(33'({access_event, 16'(n)}), 33'({ev, 16'(cyc)}), "end event");
  endtask : wait_end
  task automatic clr(input logic sel);
    @(posedge clk_sys);
    perm_sel_read <= sel;
    perm_wr_clear <= 128'h1;
    @(posedge clk_sys);
    perm_wr_clear <= '0;
  endtask : clr
  task automatic stop_test;
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // Answers are matched in issue order, one per read
  always @(negedge clk_sys) begin
    if (rd_valid || bus_fault) begin
      chk({bus_fault, rdata}, exp_q.pop_front(), "read answer");
    end
  end
  initial begin
    #(2000 * 8);
    error_cnt++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk({&ppermit, &rpermit, ucount}, {2'b11, IFSC_USEC_RESET}, "reset values");
    d1 = $random(seed);
    d2 = $random(seed);
    wr(IFSC_SRAM_BASE + 32'h1000, d1);
    wr(IFSC_ALIAS_BASE + 32'h1000 * 32 + 3 * 4, 32'h0);
    rd(IFSC_SRAM_BASE + 32'h1000, 1'b0, {1'b0, d1 & ~32'h8});
    rd(IFSC_ALIAS_BASE + 32'h20010, 1'b0, {32'h0, d1[4]});
    wr(IFSC_SRAM_BASE + 32'hfffc, d2);
    rd(IFSC_SRAM_BASE + 32'hfffc, 1'b0, {1'b0, d2});
    rd(32'h1000_0000, 1'b0, {1'b1, 32'h0});
    op(1'b0, 16'h0, '0);
    wait_end(1'b0, ERASE_N);
    op(1'b1, 16'h1, d1);
    wait_end(1'b0, PROG_N);
    op(1'b1, 16'h1, d2);
    wait_end(1'b0, PROG_N);
    rd(32'h3fc, 1'b0, {1'b0, IFSC_WORD_ONES});
    op(1'b0, 16'h200, '0);
    op(1'b1, 16'h201, '0);
    // Second request lands while busy and two cycles after the erase was taken
    wait_end(1'b0, ERASE_N - 2);
    rd(32'h804, 1'b0, {1'b0, IFSC_WORD_ONES});
    rd(32'h4, 1'b0, {1'b0, d1 & d2});
    clr(1'b0);
    op(1'b1, 16'h2, '0);
    wait_end(1'b1, 1);
    rd(32'h8, 1'b0, {1'b0, IFSC_WORD_ONES});
    op(1'b0, 16'h100, '0);
    wait_end(1'b1, 1);
    clr(1'b1);
    rd(32'h4, 1'b0, {1'b1, 32'h0});
    rd(32'h4, 1'b1, {1'b0, d1 & d2});
    repeat (3) @(posedge clk_sys);
    chk(33'(exp_q.size()), 33'h0, "pending reads");
    chk(33'(ucount), 33'(RELOAD), "reload count");
    chk(33'({ppermit[1:0], rpermit[1:0]}), 33'(4'b1010), "permits");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
